// ===== hdl/assert_filter.sv
// Qualifies an active-high level: asserts only after it holds for CYCLES
`timescale 1ns/100ps
module assert_filter #(
   parameter int CYCLES = 4
) (
   input wire logic sys_clk, // System clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic raw_in, // Unqualified level
   output logic qual_out // Qualified level
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_q;

   generate
      if (CYCLES < 1) begin : g_chk
         $error("assert_filter CYCLES must be at least 1");
      end
   endgenerate

   // Release is immediate; only the assertion edge is filtered
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
         qual_out <= 1'b0;
      end else if (!raw_in) begin
         cnt_q <= '0;
         qual_out <= 1'b0;
      end else if (cnt_q == W'(CYCLES - 1)) begin
         qual_out <= 1'b1;
      end else begin
         cnt_q <= cnt_q + W'(1);
      end
   end
endmodule

// ===== hdl/reset_seq_defs.svh
// Timing counts, field encodings and reset values of the reset sequencer
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH

`define SYS_CLK_MHZ 40
`define RC_TICK_NS 1000
`define RC_DIV_CYCLES ((`RC_TICK_NS * `SYS_CLK_MHZ) / 1000)
`define PUP_TIME_MS 64
`define PUP_TICKS ((`PUP_TIME_MS * 1000000) / `RC_TICK_NS)
`define XTAL_CYCLES 1024
`define PIN_FILTER_NS 250
`define PIN_FILTER_CYCLES ((`PIN_FILTER_NS * `SYS_CLK_MHZ + 999) / 1000)
`define DIP_MIN_NS 1000
`define DIP_MIN_CYCLES ((`DIP_MIN_NS * `SYS_CLK_MHZ + 999) / 1000)

`define BOM_ALWAYS 2'h3
`define BOM_AWAKE 2'h2
`define OSC_LAST_CRYSTAL 3'h2

`define POR_FLAG_RST 1'h0
`define DIP_FLAG_RST 1'h0
`define TMO_FLAG_RST 1'h1
`define PDN_FLAG_RST 1'h1

`endif

// ===== hdl/reset_seq_pkg.sv
// Types shared by the reset sequencer modules
package reset_seq_pkg;
   typedef enum logic [2:0] {
      ST_POR, ST_DIP, ST_PUP, ST_XTAL, ST_HOLD, ST_RUN
   } seq_state_e;

   typedef enum logic [2:0] {
      CAUSE_POR, CAUSE_DOG_RUN, CAUSE_DOG_SLEEP,
      CAUSE_PIN_RUN, CAUSE_PIN_SLEEP, CAUSE_DIP
   } reset_cause_e;

   typedef logic [1:0] brown_out_mode_t;
   typedef logic [2:0] osc_mode_t;
endpackage

// ===== hdl/reset_timeout_sequencer.sv
// Reset sequencer: source merge, start-up timers and reset cause flags
`timescale 1ns/100ps
`include "reset_seq_defs.svh"
module reset_timeout_sequencer
   import reset_seq_pkg::*;
#(
   parameter int PUP_TICKS = `PUP_TICKS,
   parameter int XTAL_CYCLES = `XTAL_CYCLES,
   parameter int RC_DIV = `RC_DIV_CYCLES,
   parameter int PIN_FILTER_CYCLES = `PIN_FILTER_CYCLES,
   parameter int DIP_MIN_CYCLES = `DIP_MIN_CYCLES
) (
   input wire logic sys_clk, // 40 MHz system clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic por_pulse, // Power-on detector active
   input wire logic brownout_detect, // Supply below threshold
   input wire logic ext_reset_pin_n, // Shared reset pin level
   input wire logic ext_reset_pin_select, // 1: pin is reset input
   input wire logic power_up_timer_disable_n, // 1: timer off
   input wire brown_out_mode_t brown_out_mode, // Brown-out mode
   input wire osc_mode_t osc_mode, // Oscillator selection
   input wire logic osc_tick, // Main oscillator cycle pulse
   input wire logic watchdog_timeout, // Watchdog expiry pulse
   input wire logic sleep_active, // Core is asleep
   input wire logic sw_set_por_flag, // Software writes 1
   input wire logic sw_set_dip_flag, // Software writes 1
   output logic chip_reset_n, // Chip reset, active low
   output logic watchdog_wake, // Wake pulse, no reinit
   output reset_cause_e reset_cause, // Last reset cause
   output logic por_flag_n, // Power-on status flag
   output logic dip_flag_n, // Brown-out status flag
   output logic timeout_flag_n, // Timeout status flag
   output logic powerdown_flag_n, // Powerdown status flag
   output logic brown_out_detect_en, // Enables analog detector
   output logic pin_pull_up_en, // Weak pull-up on pin
   output logic pin_oe_n, // Pin driver enable, low drives
   output logic shared_input_pin // Pin as digital input
);

   //-------------------------------------------------------------------
   // Parameter checks
   //-------------------------------------------------------------------
   generate
      if (PUP_TICKS < 1 || XTAL_CYCLES < 1 || RC_DIV < 1) begin : g_chk
         $error("sequencer counts must be at least 1");
      end
   endgenerate

   localparam int DW = $clog2(RC_DIV + 1);

   seq_state_e state_q, state_d;
   logic [DW-1:0] rc_div_q;
   logic rc_tick_q;
   logic pin_raw, pin_qual, pin_reset;
   logic dip_raw, dip_qual, dip_enabled;
   logic pup_enabled, crystal_mode;
   logic pup_done, xtal_done;
   logic ev_por, ev_dip, ev_pin_run, ev_pin_sleep;
   logic ev_dog_run, ev_dog_wake;
   logic supply_low;

   //-------------------------------------------------------------------
   // Internal RC time base
   //-------------------------------------------------------------------
   // A divided tick stands in for the RC oscillator so one clock serves
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rc_div_q <= '0;
         rc_tick_q <= 1'b0;
      end else if (rc_div_q == DW'(RC_DIV - 1)) begin
         rc_div_q <= '0;
         rc_tick_q <= 1'b1;
      end else begin
         rc_div_q <= rc_div_q + DW'(1);
         rc_tick_q <= 1'b0;
      end
   end

   //-------------------------------------------------------------------
   // Reset sources
   //-------------------------------------------------------------------
   // Pin only counts as reset when selected; otherwise it is plain input
   assign pin_raw = ext_reset_pin_select & ~ext_reset_pin_n;

   assert_filter #(
      .CYCLES(PIN_FILTER_CYCLES)
   ) u_pin_filter (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .raw_in(pin_raw),
      .qual_out(pin_qual)
   );

   assign pin_reset = pin_qual & ext_reset_pin_select;

   always_comb begin
      dip_enabled = 1'b0;
      if (brown_out_mode == `BOM_ALWAYS) begin
         dip_enabled = 1'b1;
      end else if (brown_out_mode == `BOM_AWAKE) begin
         dip_enabled = ~sleep_active;
      end
   end

   assign dip_raw = dip_enabled & brownout_detect;

   // Dips shorter than the minimum duration are not treated as brown-out
   assert_filter #(
      .CYCLES(DIP_MIN_CYCLES)
   ) u_dip_filter (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .raw_in(dip_raw),
      .qual_out(dip_qual)
   );

   // Release from power-on or brown-out waits for the supply while the detector is enabled
   assign supply_low = dip_raw;

   assign pup_enabled = ~power_up_timer_disable_n;
   assign crystal_mode = (osc_mode <= `OSC_LAST_CRYSTAL);

   //-------------------------------------------------------------------
   // Start-up timers
   //-------------------------------------------------------------------
   // Any departure from the counting state clears the count
   tick_counter #(
      .TARGET(PUP_TICKS)
   ) u_pup (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clear(state_q != ST_PUP),
      .tick(rc_tick_q),
      .done(pup_done)
   );

   tick_counter #(
      .TARGET(XTAL_CYCLES)
   ) u_xtal (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clear(state_q != ST_XTAL),
      .tick(osc_tick),
      .done(xtal_done)
   );

   //-------------------------------------------------------------------
   // Reset events
   //-------------------------------------------------------------------
   // Priority: power-on, brown-out, pin, watchdog
   always_comb begin
      ev_por = por_pulse && (state_q != ST_POR);
      ev_dip = !por_pulse && dip_qual && (state_q != ST_POR) &&
         (state_q != ST_DIP);
      ev_pin_run = 1'b0;
      ev_pin_sleep = 1'b0;
      ev_dog_run = 1'b0;
      ev_dog_wake = 1'b0;
      if (!por_pulse && !dip_qual && state_q == ST_RUN) begin
         if (pin_reset) begin
            ev_pin_run = ~sleep_active;
            ev_pin_sleep = sleep_active;
         end else if (watchdog_timeout) begin
            ev_dog_run = ~sleep_active;
            ev_dog_wake = sleep_active;
         end
      end
   end

   //-------------------------------------------------------------------
   // Sequencing state machine
   //-------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      if (por_pulse) begin
         state_d = ST_POR;
      end else if (dip_qual) begin
         state_d = ST_DIP;
      end else begin
         unique case (state_q)
            ST_POR, ST_DIP: begin
               if (!supply_low) begin
                  if (pup_enabled) begin
                     state_d = ST_PUP;
                  end else if (crystal_mode) begin
                     state_d = ST_XTAL;
                  end else begin
                     state_d = ST_HOLD;
                  end
               end
            end
            ST_PUP: begin
               // Pin level is ignored here so the count runs on
               if (pup_done) begin
                  state_d = crystal_mode ? ST_XTAL : ST_HOLD;
               end
            end
            ST_XTAL: begin
               if (xtal_done) begin
                  state_d = ST_HOLD;
               end
            end
            ST_HOLD: begin
               // Timers already expired: pin release starts at once
               if (!pin_reset) begin
                  state_d = ST_RUN;
               end
            end
            ST_RUN: begin
               // Watchdog reset re-enters hold without the timers
               if (ev_pin_run || ev_pin_sleep || ev_dog_run) begin
                  state_d = ST_HOLD;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_POR;
      end else begin
         state_q <= state_d;
      end
   end

   //-------------------------------------------------------------------
   // Chip reset and wake outputs
   //-------------------------------------------------------------------
   // Every non-run state holds the chip, so registers load defaults
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         chip_reset_n <= 1'b0;
      end else begin
         chip_reset_n <= (state_d == ST_RUN);
      end
   end

   // Wake-up is a pulse only; chip reset stays released
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         watchdog_wake <= 1'b0;
      end else begin
         watchdog_wake <= ev_dog_wake;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reset_cause <= CAUSE_POR;
      end else if (ev_por) begin
         reset_cause <= CAUSE_POR;
      end else if (ev_dip) begin
         reset_cause <= CAUSE_DIP;
      end else if (ev_pin_run) begin
         reset_cause <= CAUSE_PIN_RUN;
      end else if (ev_pin_sleep) begin
         reset_cause <= CAUSE_PIN_SLEEP;
      end else if (ev_dog_run) begin
         reset_cause <= CAUSE_DOG_RUN;
      end else if (ev_dog_wake) begin
         reset_cause <= CAUSE_DOG_SLEEP;
      end
   end

   //-------------------------------------------------------------------
   // Status flags
   //-------------------------------------------------------------------
   // Hardware clears win over a software write in the same cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         por_flag_n <= `POR_FLAG_RST;
      end else if (ev_por) begin
         por_flag_n <= 1'b0;
      end else if (sw_set_por_flag) begin
         por_flag_n <= 1'b1;
      end
   end

   // Power-on leaves this flag as it was; its value is not meaningful
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dip_flag_n <= `DIP_FLAG_RST;
      end else if (ev_dip) begin
         dip_flag_n <= 1'b0;
      end else if (sw_set_dip_flag && !ev_por) begin
         dip_flag_n <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         timeout_flag_n <= `TMO_FLAG_RST;
      end else if (ev_por || ev_dip || ev_pin_sleep) begin
         timeout_flag_n <= 1'b1;
      end else if (ev_dog_run || ev_dog_wake) begin
         timeout_flag_n <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         powerdown_flag_n <= `PDN_FLAG_RST;
      end else if (ev_por || ev_dip) begin
         powerdown_flag_n <= 1'b1;
      end else if (ev_dog_wake || ev_pin_sleep) begin
         powerdown_flag_n <= 1'b0;
      end
   end

   //-------------------------------------------------------------------
   // Pin and detector controls
   //-------------------------------------------------------------------
   // The pin has no pull-down driver; watchdog never pulls it low
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_oe_n <= 1'b1;
      end else begin
         pin_oe_n <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_pull_up_en <= 1'b0;
         shared_input_pin <= 1'b0;
      end else begin
         pin_pull_up_en <= ext_reset_pin_select;
         shared_input_pin <= ext_reset_pin_select ? 1'b0 :
            ext_reset_pin_n;
      end
   end

   // Turning the detector off in sleep saves current
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         brown_out_detect_en <= 1'b0;
      end else begin
         brown_out_detect_en <= dip_enabled;
      end
   end

endmodule

// ===== hdl/tick_counter.sv
// Counts enable ticks up to TARGET and then holds done high until cleared
`timescale 1ns/100ps
module tick_counter #(
   parameter int TARGET = 16
) (
   input wire logic sys_clk, // System clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic clear, // Restart the count
   input wire logic tick, // One-cycle count enable
   output logic done // Count reached
);
   localparam int W = $clog2(TARGET + 1);
   logic [W-1:0] cnt_q;

   generate
      if (TARGET < 1) begin : g_chk
         $error("tick_counter TARGET must be at least 1");
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
         done <= 1'b0;
      end else if (clear) begin
         cnt_q <= '0;
         done <= 1'b0;
      end else if (tick && !done) begin
         cnt_q <= cnt_q + W'(1);
         done <= (cnt_q == W'(TARGET - 1));
      end
   end
endmodule

// ===== sim/board_model.sv
// Board model: supply monitors, reset pin and main oscillator
`timescale 1ns/100ps
module board_model (
   input wire logic sys_clk, // System clock
   input wire logic pin_pull_up_en, // Device weak pull-up
   output logic por_pulse, // Power-on detector
   output logic brownout_detect, // Supply low
   output logic ext_reset_pin_n, // Pin level
   output logic osc_tick // Oscillator cycle pulse
);
   //---------------------------------------------
   // Pin and supply drivers
   //---------------------------------------------
   logic pin_low = 1'b0;
   logic pin_drive = 1'b0;
   logic pin_val = 1'b0;
   logic drift = 1'b0;
   initial begin
      por_pulse = 1'b0;
      brownout_detect = 1'b0;
      osc_tick = 1'b0;
   end
   always @(negedge sys_clk) begin
      osc_tick <= !osc_tick;
      drift <= !drift;
   end
   // An undriven pin without pull-up wanders rather than holding a level
   assign ext_reset_pin_n = pin_low ? 1'b0 : pin_drive ? pin_val :
      pin_pull_up_en ? 1'b1 : drift;
   task automatic pulse(input int k, input int n);
      @(negedge sys_clk);
      if (k == 0) por_pulse = 1'b1;
      else brownout_detect = 1'b1;
      repeat (n) @(negedge sys_clk);
      por_pulse = 1'b0;
      brownout_detect = 1'b0;
   endtask
endmodule

// ===== sim/reset_seq_monitor.sv
// Port checker for the reset sequencer
`timescale 1ns/100ps
module reset_seq_monitor
   import reset_seq_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic resetn, // Reset
   input wire logic por_pulse, // Power-on
   input wire logic brownout_detect, // Raw dip
   input wire logic ext_reset_pin_n, // Pin
   input wire logic ext_reset_pin_select, // Pin mode
   input wire brown_out_mode_t brown_out_mode, // Mode
   input wire logic watchdog_timeout, // Expiry
   input wire logic sleep_active, // Asleep
   input wire logic chip_reset_n, // Chip reset
   input wire logic watchdog_wake, // Wake
   input wire reset_cause_e reset_cause, // Cause
   input wire logic por_flag_n, // Flag
   input wire logic dip_flag_n, // Flag
   input wire logic timeout_flag_n, // Flag
   input wire logic powerdown_flag_n, // Flag
   input wire logic brown_out_detect_en, // Detector on
   input wire logic pin_pull_up_en, // Pull-up
   input wire logic pin_oe_n, // Driver
   input wire logic shared_input_pin // Pin data
);
   //---------------------------------------------
   // Checks
   //---------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Power-on and brown-out would mask the pin event; a watchdog expiry would add a reset of its own
   wire logic quiet = !por_pulse && !brownout_detect && !watchdog_timeout;
   sequence dog_run_s;
      watchdog_timeout && chip_reset_n && !sleep_active
      && !por_pulse && !brownout_detect;
   endsequence
   sequence dog_sleep_s;
      watchdog_timeout && chip_reset_n && sleep_active
      && !por_pulse && !brownout_detect;
   endsequence
   sequence blip_s;
      (quiet && ext_reset_pin_n) ##1 (quiet && !ext_reset_pin_n
      && ext_reset_pin_select && chip_reset_n) ##1 (quiet && ext_reset_pin_n);
   endsequence
   chk_pin_undriven: assert property (pin_oe_n)
      else $error("pin driver enabled");
   chk_input_follow: assert property (!ext_reset_pin_select |=>
      shared_input_pin == $past(ext_reset_pin_n))
      else $error("shared input does not follow pin");
   chk_pull_up: assert property (ext_reset_pin_select |=> pin_pull_up_en)
      else $error("pull-up missing");
   chk_dog_reset: assert property (dog_run_s |=> !chip_reset_n
      && reset_cause == CAUSE_DOG_RUN && !timeout_flag_n ##2 chip_reset_n)
      else $error("watchdog reset sequence wrong");
   chk_dog_wake: assert property (dog_sleep_s |=> watchdog_wake
      && chip_reset_n && reset_cause == CAUSE_DOG_SLEEP && !timeout_flag_n
      && !powerdown_flag_n ##1 !watchdog_wake)
      else $error("watchdog wake wrong");
   chk_pin_filter: assert property (blip_s |=> chip_reset_n [*2])
      else $error("short pin pulse caused reset");
   chk_por_flags: assert property ($fell(chip_reset_n)
      && reset_cause == CAUSE_POR |-> !por_flag_n && timeout_flag_n
      && powerdown_flag_n) else $error("power-on flags wrong");
   chk_dip_flags: assert property ($fell(chip_reset_n)
      && reset_cause == CAUSE_DIP |-> !dip_flag_n && timeout_flag_n
      && powerdown_flag_n && $stable(por_flag_n))
      else $error("brown-out flags wrong");
   chk_pin_sleep: assert property ($fell(chip_reset_n)
      && reset_cause == CAUSE_PIN_SLEEP |-> timeout_flag_n
      && !powerdown_flag_n) else $error("pin sleep flags wrong");
   chk_dip_resets: assert property (
      (brown_out_mode == 2'h3 && brownout_detect) [*3] |-> ##[1:2]
      !chip_reset_n) else $error("brown-out did not reset");
   chk_detect_off: assert property (
      (brown_out_mode[1] == 1'b0) [*2] |-> !brown_out_detect_en)
      else $error("detector on while disabled");
   chk_sleep_off: assert property (
      (brown_out_mode == 2'h2 && sleep_active) [*2] |-> !brown_out_detect_en)
      else $error("detector on in sleep");
endmodule
bind reset_timeout_sequencer reset_seq_monitor mon_u (.sys_clk, .resetn,
   .por_pulse, .brownout_detect, .ext_reset_pin_n, .ext_reset_pin_select,
   .brown_out_mode, .watchdog_timeout, .sleep_active, .chip_reset_n,
   .watchdog_wake, .reset_cause, .por_flag_n, .dip_flag_n, .timeout_flag_n,
   .powerdown_flag_n, .brown_out_detect_en, .pin_pull_up_en, .pin_oe_n,
   .shared_input_pin);

// ===== sim/reset_timeout_sequencer_test.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
module reset_timeout_sequencer_test;
   import reset_seq_pkg::*;
   localparam int PUP = 20;
   localparam int XTAL = 4;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic por_pulse, brownout_detect, ext_reset_pin_n, osc_tick;
   logic ext_reset_pin_select = 1'b1;
   logic power_up_timer_disable_n = 1'b0;
   brown_out_mode_t brown_out_mode = 2'h3;
   osc_mode_t osc_mode = 3'h0;
   logic watchdog_timeout = 1'b0;
   logic sleep_active = 1'b0;
   logic sw_set_por_flag = 1'b0;
   logic sw_set_dip_flag = 1'b0;
   logic chip_reset_n, watchdog_wake, por_flag_n, dip_flag_n;
   logic timeout_flag_n, powerdown_flag_n, brown_out_detect_en;
   logic pin_pull_up_en, pin_oe_n, shared_input_pin;
   reset_cause_e reset_cause;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   always #12.5 sys_clk = !sys_clk;
   reset_timeout_sequencer #(.PUP_TICKS(PUP), .XTAL_CYCLES(XTAL),
      .RC_DIV(2), .PIN_FILTER_CYCLES(2), .DIP_MIN_CYCLES(2)) dut_u (.*);
   board_model board_u (.sys_clk, .pin_pull_up_en, .por_pulse,
      .brownout_detect, .ext_reset_pin_n, .osc_tick);
   //---------------------------------------------
   // Helpers
   //---------------------------------------------
   task wrap_up;
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Ceiling sized well above the longest sequence below
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         wrap_up();
      end
   end
   task check(input string what, input logic [7:0] seen, exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task span(input string what, input int v, lo, hi);
      check(what, 8'(v >= lo && v <= hi), 8'h1);
   endtask
   task flags(input reset_cause_e c, input logic t, p);
      check("cause", 8'(reset_cause), 8'(c));
      check("timeout flag", 8'(timeout_flag_n), 8'(t));
      check("powerdown flag", 8'(powerdown_flag_n), 8'(p));
   endtask
   task wait_run(output int k);
      k = 0;
      while (chip_reset_n !== 1'b1 && k < 400) begin
         @(negedge sys_clk);
         k = k + 1;
      end
   endtask
   task automatic strobe(ref logic s);
      @(negedge sys_clk);
      s = 1'b1;
      @(negedge sys_clk);
      s = 1'b0;
   endtask
   task pin(input int k);
      @(negedge sys_clk);
      board_u.pin_low = 1'b1;
      repeat (k) @(negedge sys_clk);
      board_u.pin_low = 1'b0;
   endtask
   //---------------------------------------------
   // Sequence
   //---------------------------------------------
   initial begin
      repeat (10) @(negedge sys_clk);
      resetn = 1'b1;
      wait_run(n);
      span("crystal start-up", n, 44, 60);
      strobe(sw_set_por_flag);
      strobe(sw_set_dip_flag);
      check("por flag set", 8'(por_flag_n), 8'h1);
      check("dip flag set", 8'(dip_flag_n), 8'h1);
      // Power-on with the pin held low: timers expire meanwhile
      board_u.pin_low = 1'b1;
      board_u.pulse(0, 5);
      repeat (80) @(negedge sys_clk);
      check("held by pin", 8'(chip_reset_n), 8'h0);
      flags(CAUSE_POR, 1'b1, 1'b1);
      check("por flag", 8'(por_flag_n), 8'h0);
      check("dip flag kept", 8'(dip_flag_n), 8'h1);
      board_u.pin_low = 1'b0;
      wait_run(n);
      span("pin release", n, 0, 4);
      strobe(sw_set_por_flag);
      board_u.pulse(1, 1);
      repeat (4) @(negedge sys_clk);
      check("short dip", 8'(chip_reset_n), 8'h1);
      board_u.pulse(1, 10);
      check("dip cause", 8'(reset_cause), 8'(CAUSE_DIP));
      check("dip flag", 8'(dip_flag_n), 8'h0);
      check("por kept", 8'(por_flag_n), 8'h1);
      repeat (30) @(negedge sys_clk);
      check("timer holds", 8'(chip_reset_n), 8'h0);
      board_u.pulse(1, 5);
      wait_run(n);
      span("timer restart", n, 44, 60);
      strobe(watchdog_timeout);
      flags(CAUSE_DOG_RUN, 1'b0, 1'b1);
      wait_run(n);
      span("watchdog no timers", n, 0, 3);
      sleep_active = 1'b1;
      strobe(watchdog_timeout);
      check("wake", 8'(watchdog_wake), 8'h1);
      check("wake no reset", 8'(chip_reset_n), 8'h1);
      flags(CAUSE_DOG_SLEEP, 1'b0, 1'b0);
      sleep_active = 1'b0;
      pin(1);
      repeat (4) @(negedge sys_clk);
      check("blip", 8'(chip_reset_n), 8'h1);
      pin(6);
      flags(CAUSE_PIN_RUN, 1'b0, 1'b0);
      wait_run(n);
      span("pin run release", n, 0, 4);
      sleep_active = 1'b1;
      pin(6);
      flags(CAUSE_PIN_SLEEP, 1'b1, 1'b0);
      sleep_active = 1'b0;
      wait_run(n);
      ext_reset_pin_select = 1'b0;
      pin(6);
      check("pin ignored", 8'(chip_reset_n), 8'h1);
      check("no pull-up", 8'(pin_pull_up_en), 8'h0);
      board_u.pin_drive = 1'b1;
      board_u.pin_val = 1'b1;
      repeat (2) @(negedge sys_clk);
      check("pin data", 8'(shared_input_pin), 8'h1);
      board_u.pin_drive = 1'b0;
      ext_reset_pin_select = 1'b1;
      for (int m = 0; m < 3; m++) begin
         brown_out_mode = 2'(m);
         sleep_active = (m == 2);
         repeat (3) @(negedge sys_clk);
         board_u.pulse(1, 10);
         check("dip masked", 8'(chip_reset_n), 8'h1);
      end
      sleep_active = 1'b0;
      repeat (3) @(negedge sys_clk);
      board_u.pulse(1, 10);
      check("awake detect", 8'(chip_reset_n), 8'h0);
      wait_run(n);
      for (int i = 0; i < 3; i++) begin
         osc_mode = (i == 0) ? 3'h3 : (i == 1) ? 3'h4 : 3'h1;
         power_up_timer_disable_n = (i != 1);
         board_u.pulse(0, 5);
         wait_run(n);
         if (i == 0) span("ext clock", n, 0, 4);
         else if (i == 1) span("rc timer", n, 38, 48);
         else span("crystal only", n, 6, 14);
      end
      wrap_up();
   end
endmodule
